//--- src/sbc_pkg.sv
/*
 * Package for the bus clock/configuration block: register address, field
 * positions, reset value, the configuration carrier struct and the
 * bit-rate source encoding.
 * Assumes a byte-wide special function register port on the system clock.
 */
`default_nettype none
package sbc_pkg;
   // Address of the configuration register on the special function port.
   localparam logic [7:0] CFG_ADDR = 8'hC1;
   // Field positions inside the configuration byte.
   localparam int POS_ENABLE = 7;
   localparam int POS_INHIBIT = 6;
   localparam int POS_BUSY = 5;
   localparam int POS_HOLD = 4;
   localparam int POS_TOUT = 3;
   localparam int POS_FREE = 2;
   localparam int POS_SRC = 0;
   // Reset value of the whole register.
   localparam logic [7:0] CFG_RESET = 8'h00;
   // Bus is free after more than this many bit-rate source periods high.
   localparam logic [3:0] FREE_PERIODS = 4'hA;
   // Recommended SCL low timeout for the timeout timer; no logic in this project uses it.
   localparam int SCL_LOW_TIMEOUT_MS = 25;

   // Bit-rate source selection.
   typedef enum logic [1:0] {
      SRC_T0_OVF = 2'h0,
      SRC_T1_OVF = 2'h1,
      SRC_T2H_OVF = 2'h2,
      SRC_T2L_OVF = 2'h3
   } sbc_src_t;

   // Writable configuration fields, carried together.
   typedef struct packed {
      logic interface_enable;
      logic slave_inhibit;
      logic sda_hold_extend;
      logic scl_low_timeout_enable;
      logic bus_free_timeout_enable;
      sbc_src_t bit_rate_source_select;
   } sbc_cfg_t;
endpackage
`default_nettype wire

//--- src/sbc_bus_clock_config.sv
/*
 * Configuration and supervision logic of the two-wire serial interface:
 * the configuration register, busy tracking, bus-free timeout, timeout
 * timer reload control, slave interrupt inhibit and bit-rate tick.
 * Assumes timer overflow pulses arrive on their own clock clk_tmr, and that
 * SCL/SDA pin levels are asynchronous and must be synchronised here.
 */
`default_nettype none
module sbc_bus_clock_config (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic clk_tmr,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic t0_ovf,
   input wire logic t1_ovf,
   input wire logic t2h_ovf,
   input wire logic t2l_ovf,
   input wire logic t3_split,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic scl_oe_n,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic slave_event,
   input wire logic master_event,
   output logic irq,
   output logic hold_extend,
   output logic t3_reload_hi,
   output logic t3_reload_lo,
   output logic bit_tick,
   output logic bus_free
);
   // Configuration register and busy flag.
   sbc_pkg::sbc_cfg_t cfg_q;
   logic busy_q;
   // Pin synchronisers; the first stage is read only by the second.
   logic [1:0] scl_sync_q;
   logic [1:0] sda_sync_q;
   logic scl_prev_q;
   logic sda_prev_q;
   // Bus-free period counter.
   logic [3:0] free_cnt_q;
   // Timer-domain reset synchroniser, source select sync and toggle.
   logic [1:0] trst_sync_q;
   logic [1:0] sel0_sync_q;
   logic [1:0] sel1_sync_q;
   // Previous synchronised select word and the select word actually in use.
   logic [1:0] sel_prev_q;
   logic [1:0] sel_use_q;
   logic tick_tog_q;
   // System-domain toggle receiver.
   logic [2:0] tog_sync_q;
   // Registered outputs.
   logic [7:0] rdata_q;
   logic irq_q;
   logic reload_hi_q;
   logic reload_lo_q;
   logic tick_q;
   logic free_q;
   logic hold_q;

   // Selects one overflow pulse according to the source field.
   function automatic logic pick_src(input logic [1:0] sel, input logic [3:0] ovf);
      pick_src = ovf[sel];
   endfunction

   // Named decode and bus event wires.
   wire cfg_hit = sfr_wr && (sfr_addr == sbc_pkg::CFG_ADDR);
   wire scl_s = scl_sync_q[1];
   wire sda_s = sda_sync_q[1];
   wire en = cfg_q.interface_enable;
   wire start_det = en && scl_s && scl_prev_q && sda_prev_q && !sda_s;
   wire stop_det = en && scl_s && scl_prev_q && !sda_prev_q && sda_s;
   wire both_high = scl_s && sda_s;
   wire tick_sys = tog_sync_q[2] ^ tog_sync_q[1];
   wire free_exp = en && cfg_q.bus_free_timeout_enable && both_high && tick_sys
                   && (free_cnt_q == sbc_pkg::FREE_PERIODS);
   wire tout_reload = en && cfg_q.scl_low_timeout_enable && scl_s;
   wire trst_n = trst_sync_q[1];
   // Select word as seen after the per-bit synchronisers in the timer domain.
   wire [1:0] sel_tmr = {sel1_sync_q[1], sel0_sync_q[1]};
   wire ovf_sel = pick_src(sel_use_q, {t2l_ovf, t2h_ovf, t1_ovf, t0_ovf});
   wire [7:0] rd_view = {cfg_q.interface_enable, cfg_q.slave_inhibit, busy_q,
                         cfg_q.sda_hold_extend, cfg_q.scl_low_timeout_enable,
                         cfg_q.bus_free_timeout_enable, cfg_q.bit_rate_source_select};

   // Timer domain: reset synchroniser and source select synchronisers.
   always_ff @(posedge clk_tmr) begin
      trst_sync_q <= {trst_sync_q[0], nrst};
      sel0_sync_q <= {sel0_sync_q[0], cfg_q.bit_rate_source_select[0]};
      sel1_sync_q <= {sel1_sync_q[0], cfg_q.bit_rate_source_select[1]};
   end

   // Timer domain: the select word is taken only when two samples agree, so a
   // skew between the two bit synchronisers can never pick a source for a cycle.
   always_ff @(posedge clk_tmr) begin
      sel_prev_q <= sel_tmr;
      if (!trst_n) begin
         sel_use_q <= sbc_pkg::SRC_T0_OVF;
      end else if (sel_prev_q == sel_tmr) begin
         sel_use_q <= sel_prev_q;
      end
   end

   // Timer domain: each selected overflow flips the toggle.
   always_ff @(posedge clk_tmr) begin
      if (!trst_n) begin
         tick_tog_q <= 1'b0;
      end else if (ovf_sel) begin
         tick_tog_q <= ~tick_tog_q;
      end
   end

   // System domain: toggle receiver; an edge makes one tick.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tog_sync_q <= 3'h0;
      end else begin
         tog_sync_q <= {tog_sync_q[1:0], tick_tog_q};
      end
   end

   // Pin synchronisers and previous-level history.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
      end
   end

   // Configuration register write; busy is read-only.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cfg_q <= sbc_sc_reset();
      end else if (cfg_hit) begin
         cfg_q <= {sfr_wdata[7:6], sfr_wdata[4:0]};
      end
   end

   // Reset value of the writable fields, taken from the register reset.
   function automatic sbc_pkg::sbc_cfg_t sbc_sc_reset();
      sbc_sc_reset = {sbc_pkg::CFG_RESET[7:6], sbc_pkg::CFG_RESET[4:0]};
   endfunction

   // Busy tracking: start sets, stop or free timeout clears; set wins.
   always_ff @(posedge clk_sys) begin
      if (!nrst || !en) begin
         busy_q <= 1'b0;
      end else if (start_det) begin
         busy_q <= 1'b1;
      end else if (stop_det || free_exp) begin
         busy_q <= 1'b0;
      end
   end

   // Counts source periods while both lines stay high.
   always_ff @(posedge clk_sys) begin
      if (!nrst || !en || !both_high || !cfg_q.bus_free_timeout_enable) begin
         free_cnt_q <= 4'h0;
      end else if (tick_sys && free_cnt_q != sbc_pkg::FREE_PERIODS) begin
         free_cnt_q <= free_cnt_q + 4'h1;
      end
   end

   // Registered outputs.
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
         irq_q <= 1'b0;
         reload_hi_q <= 1'b0;
         reload_lo_q <= 1'b0;
         tick_q <= 1'b0;
         free_q <= 1'b1;
         hold_q <= 1'b0;
      end else begin
         rdata_q <= rd_view;
         irq_q <= en && (master_event || (slave_event && !cfg_q.slave_inhibit));
         reload_hi_q <= tout_reload;
         reload_lo_q <= tout_reload && !t3_split;
         tick_q <= en && tick_sys;
         free_q <= !busy_q || stop_det || free_exp;
         hold_q <= en && cfg_q.sda_hold_extend;
      end
   end

   // Lines stay released: driving is left to the byte-level engine.
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n = 1'b1;
   assign sda_oe_n = 1'b1;
   assign sfr_rdata = rdata_q;
   assign irq = irq_q;
   assign hold_extend = hold_q;
   assign t3_reload_hi = reload_hi_q;
   assign t3_reload_lo = reload_lo_q;
   assign bit_tick = tick_q;
   assign bus_free = free_q;

   // Watches that guard the block's behaviour.
   sequence start_seq;
      en && scl_s && scl_prev_q && sda_prev_q && !sda_s;
   endsequence

   busy_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      start_seq |=> busy_q) else $error("Busy not set after start.");
   busy_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (stop_det && !start_det && en) |=> !busy_q) else $error("Busy not cleared by stop.");
   disabled_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      !en |=> !busy_q && scl_oe_n && sda_oe_n) else $error("Disabled block not idle.");
   inhibit_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (slave_event && !master_event && cfg_q.slave_inhibit) |=> !irq)
      else $error("Inhibited slave event raised interrupt.");
   master_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (master_event && en) |=> irq) else $error("Master event lost.");
   reload_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (en && cfg_q.scl_low_timeout_enable && scl_s) |=> t3_reload_hi)
      else $error("Timer not held in reload while SCL high.");
   split_low_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      t3_split |=> !t3_reload_lo) else $error("Low byte held in split mode.");
   free_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      free_exp |-> $past(free_cnt_q) >= sbc_pkg::FREE_PERIODS - 4'h1)
      else $error("Free timeout too early.");
   free_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (free_exp && !start_det) |=> !busy_q && bus_free)
      else $error("Free timeout did not free the bus.");
   tick_single_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      tick_sys |=> !tick_sys) else $error("Tick longer than one cycle.");
   hold_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (en && cfg_q.sda_hold_extend) |=> hold_extend) else $error("Hold extend not applied.");
endmodule // sbc_bus_clock_config
`default_nettype wire

//--- testbench/sbc_bus_agent.sv
/*
 * Model of another master on the two-wire bus lines.
 * Assumes open-drain wiring: the bench ands every party's level.
 */
`default_nettype none
module sbc_bus_agent (
   input wire logic clk_sys,
   output logic scl_drv,
   output logic sda_drv
);
   timeunit 1ns;
   timeprecision 100ps;
   // A 1 releases the line, so the pull-up gives a high level.
   initial begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   // Moves both lines just after an edge, then holds them steady.
   task automatic put(input logic c, input logic d);
      @(posedge clk_sys);
      scl_drv <= c;
      sda_drv <= d;
      repeat (6) @(posedge clk_sys);
   endtask
endmodule // sbc_bus_agent
`default_nettype wire

//--- testbench/sbc_bus_clock_config_bench.sv
/*
 * Self-checking bench for the bus configuration block.
 * Assumes the agent model drives the far side of the bus lines.
 */
`default_nettype none
module sbc_bus_clock_config_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0, clk_tmr = 1'b0, nrst = 1'b0, sfr_wr = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, w;
   logic t3_split = 1'b0, slave_event = 1'b0, master_event = 1'b0;
   logic [3:0] ovf = 4'h0;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, irq, hold_extend;
   logic t3_reload_hi, t3_reload_lo, bit_tick, bus_free, scl_drv, sda_drv, scl_w, sda_w;
   int bad_count = 0, cmp_count = 0, ticks = 0, irqs = 0, t0, t3_cnt = 0;
   logic [31:0] lfsr_q = 32'h1A35;
   // Wired-and of the open-drain lines.
   assign scl_w = scl_drv & (scl_oe_n | scl_o);
   assign sda_w = sda_drv & (sda_oe_n | sda_o);
   always #12.5 clk_sys = ~clk_sys;
   always #15 clk_tmr = ~clk_tmr;
   // Counts the single-cycle pulses of the design, and stands in for the timeout
   // timer that software arms for a long SCL low: it restarts while reload is held.
   always @(posedge clk_sys) begin
      if (bit_tick === 1'b1) ticks++;
      if (irq === 1'b1) irqs++;
      if (t3_reload_hi === 1'b1) t3_cnt = 0;
      else t3_cnt++;
   end
   sbc_bus_clock_config u_sbc_bus_clock_config (.clk_sys(clk_sys), .nrst(nrst),
      .clk_tmr(clk_tmr), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .t0_ovf(ovf[0]), .t1_ovf(ovf[1]), .t2h_ovf(ovf[2]),
      .t2l_ovf(ovf[3]), .t3_split(t3_split), .scl_i(scl_w), .sda_i(sda_w),
      .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
      .slave_event(slave_event), .master_event(master_event), .irq(irq),
      .hold_extend(hold_extend), .t3_reload_hi(t3_reload_hi),
      .t3_reload_lo(t3_reload_lo), .bit_tick(bit_tick), .bus_free(bus_free));
   sbc_bus_agent u_sbc_bus_agent (.clk_sys(clk_sys), .scl_drv(scl_drv), .sda_drv(sda_drv));
   // Next value of the random sequence.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Expected readback of a write while idle: the busy bit reads 0.
   function automatic logic [7:0] exp_cfg(input logic [7:0] d);
      return d & 8'hDF;
   endfunction
   // Compares one byte-wide result.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One register write, then time for the readback to settle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk_sys);
      sfr_wr <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask
   // One overflow pulse on the timer clock, spaced to avoid merging; the lead-in
   // lets a freshly written source select settle in the timer domain first.
   task automatic pulse(input int src);
      repeat (3) @(posedge clk_tmr);
      ovf[src] <= 1'b1;
      @(posedge clk_tmr);
      ovf[src] <= 1'b0;
      repeat (3) @(posedge clk_tmr);
      repeat (6) @(posedge clk_sys);
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      #400000;
      bad_count++;
      stop_test();
   end
   // Main sequence.
   initial begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk(sfr_rdata, sbc_pkg::CFG_RESET);
      u_sbc_bus_agent.put(1'b1, 1'b0);
      chk(sfr_rdata, 8'h00);
      chk({4'h0, scl_o, sda_o, scl_oe_n, sda_oe_n}, 8'h03);
      u_sbc_bus_agent.put(1'b1, 1'b1);
      // Random writes, each followed by an unmapped write that must not land.
      for (int i = 0; i < 12; i++) begin
         lfsr_q = lfsr(lfsr_q);
         w = lfsr_q[7:0];
         wr(sbc_pkg::CFG_ADDR, w);
         wr({1'b0, w[6:0]}, ~w);
         chk(sfr_rdata, exp_cfg(w));
         chk({7'h00, hold_extend}, {7'h00, w[7] & w[4]});
      end
      // Timeout timer reload against SCL level and split mode.
      wr(sbc_pkg::CFG_ADDR, 8'h88);
      for (int k = 0; k < 4; k++) begin
         t3_split <= k[0];
         u_sbc_bus_agent.put(k[1], 1'b1);
         chk({6'h00, t3_reload_hi, t3_reload_lo}, {6'h00, k[1], k[1] & ~k[0]});
         chk({7'h00, t3_cnt == 0}, {7'h00, k[1]});
      end
      // Only the selected overflow makes a tick.
      for (int s = 0; s < 4; s++) begin
         wr(sbc_pkg::CFG_ADDR, 8'h80 | 8'(s));
         for (int j = 0; j < 4; j++) begin
            t0 = ticks;
            pulse(j);
            chk(8'(ticks - t0), 8'(j == s));
         end
      end
      // Start sets busy; free timeout clears it only at the eleventh tick.
      wr(sbc_pkg::CFG_ADDR, 8'h84);
      u_sbc_bus_agent.put(1'b1, 1'b0);
      chk({sfr_rdata[7:1], bus_free}, 8'hA4);
      u_sbc_bus_agent.put(1'b0, 1'b0);
      u_sbc_bus_agent.put(1'b0, 1'b1);
      u_sbc_bus_agent.put(1'b1, 1'b1);
      repeat (10) pulse(0);
      chk(sfr_rdata, 8'hA4);
      pulse(0);
      chk({sfr_rdata[7:1], bus_free}, 8'h85);
      // Start then stop, and a start cut short by disabling.
      u_sbc_bus_agent.put(1'b1, 1'b0);
      u_sbc_bus_agent.put(1'b1, 1'b1);
      chk({sfr_rdata[7:1], bus_free}, 8'h85);
      u_sbc_bus_agent.put(1'b1, 1'b0);
      wr(sbc_pkg::CFG_ADDR, 8'h00);
      chk({sfr_rdata[7:1], bus_free}, 8'h01);
      u_sbc_bus_agent.put(1'b1, 1'b1);
      // Slave and master events with the inhibit off and on.
      for (int k = 0; k < 4; k++) begin
         wr(sbc_pkg::CFG_ADDR, {1'b1, k[1], 6'h00});
         t0 = irqs;
         if (k[0]) master_event <= 1'b1;
         else slave_event <= 1'b1;
         @(posedge clk_sys);
         master_event <= 1'b0;
         slave_event <= 1'b0;
         repeat (4) @(posedge clk_sys);
         chk(8'(irqs - t0), {7'h00, k[0] | ~k[1]});
      end
      stop_test();
   end
endmodule // sbc_bus_clock_config_bench
`default_nettype wire
